// ---- hw/pcs_client_mgmt_port_shell.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_shell_map.vh"

module pcs_client_mgmt_port_shell (
   input  wire       mclk,
   input  wire       resetn,
   input  wire       reset,
   input  wire       reset_done,
   input  wire       basex_or_sgmii,
   input  wire [7:0] gmii_txd,
   input  wire       gmii_tx_en,
   input  wire       gmii_tx_er,
   output reg  [7:0] gmii_rxd,
   output reg        gmii_rx_dv,
   output reg        gmii_rx_er,
   output reg        gmii_isolate,
   input  wire       mdc,
   input  wire       mdio_in,
   output reg        mdio_out,
   output reg        mdio_tri,
   input  wire [4:0] phyad,
   output reg        sgmii_mode,
   output reg        link_ready
);

   // ****************************************************
   // reset combine
   // ****************************************************
   reg [2:0] rst_sync_reg;
   wire      rst_any = ~resetn | rst_sync_reg[2];

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         rst_sync_reg <= 3'h7;                     // see R10
      end else begin
         rst_sync_reg <= {rst_sync_reg[1:0], 1'b0};
      end
   end

   // ****************************************************
   // input synchronisers
   // ****************************************************
   reg [2:0] mdc_s_reg;
   reg [2:0] mdi_s_reg;
   reg [2:0] rdone_s_reg;
   reg       mdc_reg;
   reg       mdi_reg;
   reg       rdone_reg;

   // second and third stages agree
   function stage_agree;
      input [2:0] s;
      begin
         stage_agree = (s[1] == s[2]);
      end
   endfunction

   always @(posedge mclk) begin
      if (rst_any) begin
         mdc_s_reg   <= 3'h0;
         mdi_s_reg   <= 3'h7;                      // see R7
         rdone_s_reg <= 3'h0;
         mdc_reg     <= 1'b0;
         mdi_reg     <= 1'b1;
         rdone_reg   <= 1'b0;
      end else begin
         mdc_s_reg   <= {mdc_s_reg[1:0], mdc};
         mdi_s_reg   <= {mdi_s_reg[1:0], mdio_in};
         rdone_s_reg <= {rdone_s_reg[1:0], reset_done};
         if (stage_agree(mdc_s_reg)) begin
            mdc_reg <= mdc_s_reg[2];
         end
         if (stage_agree(mdi_s_reg)) begin
            mdi_reg <= mdi_s_reg[2];
         end
         if (stage_agree(rdone_s_reg)) begin
            rdone_reg <= rdone_s_reg[2];                  // see R11
         end
      end
   end

   wire mdc_steady = stage_agree(mdc_s_reg);
   wire mdc_rise   = mdc_steady & mdc_s_reg[2] & ~mdc_reg;   // see R16
   wire mdc_fall   = mdc_steady & ~mdc_s_reg[2] & mdc_reg;
   wire rdone      = rdone_reg;                               // see R11

   // ****************************************************
   // mdio frame engine
   // ****************************************************
   localparam S_PRE  = 5'b00001;
   localparam S_HDR  = 5'b00010;
   localparam S_TA   = 5'b00100;
   localparam S_DATA = 5'b01000;
   localparam S_RDY  = 5'b10000;

   reg [4:0]             state_reg;
   reg [`MDIO_CNT_W-1:0] cnt_reg;
   reg [13:0]            hdr_reg;
   reg [15:0]            sh_reg;
   reg                   rd_reg;
   reg                   mine_reg;
   reg [15:0]            ctrl_reg;
   reg                   mode_reg;
   reg                   strap_done_reg;

   wire [1:0] hdr_op  = hdr_reg[11:10];
   wire [4:0] hdr_phy = hdr_reg[9:5];
   wire [4:0] hdr_reg_a = hdr_reg[4:0];

   // ****************************************************
   // frame helpers
   // ****************************************************
   wire in_ta   = (state_reg == S_TA);
   wire in_data = (state_reg == S_DATA);
   wire in_rdy  = (state_reg == S_RDY);

   function [15:0] rd_word;
      input [4:0] a;
      begin
         case (a)
            `MDIO_REG_CTRL: rd_word = ctrl_reg;
            `MDIO_REG_STAT: rd_word = `STAT_VAL;
            `MDIO_REG_MODE: rd_word = {15'h0000, mode_reg};
            default:        rd_word = 16'h0000;
         endcase
      end
   endfunction

   // bit counter step, wraps at the counter width
   function [`MDIO_CNT_W-1:0] cnt_inc;
      input [`MDIO_CNT_W-1:0] c;
      begin
         cnt_inc = c + 1'b1;
      end
   endfunction

   always @(posedge mclk) begin
      if (rst_any) begin
         state_reg      <= S_PRE;
         cnt_reg        <= {`MDIO_CNT_W{1'b0}};
         hdr_reg        <= 14'h0000;
         sh_reg         <= 16'h0000;
         rd_reg         <= 1'b0;
         mine_reg       <= 1'b0;
      end else begin
         if (mdc_rise) begin
            case (state_reg)
               S_PRE: begin
                  // count preamble ones, capped
                  if (mdi_reg) begin
                     if (cnt_reg != `MDIO_PRE_LEN) begin
                        cnt_reg <= cnt_inc(cnt_reg);
                     end
                  end else if (cnt_reg == `MDIO_PRE_LEN) begin
                     state_reg <= S_HDR;
                     hdr_reg   <= 14'h0000;
                     cnt_reg   <= 6'd1;
                  end else begin
                     cnt_reg <= {`MDIO_CNT_W{1'b0}};
                  end
               end
               S_HDR: begin
                  // st low bit, op, phy and reg address
                  hdr_reg <= {hdr_reg[12:0], mdi_reg};
                  cnt_reg <= cnt_inc(cnt_reg);
                  if (cnt_reg == `MDIO_HDR_LAST) begin
                     state_reg <= S_TA;
                     cnt_reg   <= {`MDIO_CNT_W{1'b0}};
                  end
               end
               S_TA: begin
                  // first turnaround bit decides the answer
                  if (cnt_reg == 6'd0) begin
                     // st lives in hdr_reg[13:12] after the header shift
                     rd_reg   <= (hdr_op == `MDIO_OP_RD);
                     mine_reg <= (hdr_reg[13:12] == `MDIO_ST) &&
                                 (hdr_phy == phyad);                  // see R8
                     sh_reg   <= rd_word(hdr_reg_a);
                     cnt_reg  <= 6'd1;
                  end else begin
                     state_reg <= S_DATA;
                     cnt_reg   <= {`MDIO_CNT_W{1'b0}};
                  end
               end
               S_DATA: begin
                  if (rd_reg) begin
                     sh_reg <= {sh_reg[14:0], 1'b0};
                  end else begin
                     sh_reg <= {sh_reg[14:0], mdi_reg};
                  end
                  cnt_reg <= cnt_inc(cnt_reg);
                  if (cnt_reg == `MDIO_DATA_LAST) begin
                     state_reg <= S_RDY;
                  end
               end
               S_RDY: begin
                  // one more rising edge commits a write
                  mine_reg  <= 1'b0;
                  state_reg <= S_PRE;
                  cnt_reg   <= mdi_reg ? 6'd1 : 6'd0;
               end
               default: begin
                  state_reg <= S_PRE;
                  cnt_reg   <= {`MDIO_CNT_W{1'b0}};
               end
            endcase
         end
      end
   end

   // ****************************************************
   // mdio output driver
   // ****************************************************
   wire drive_slot = rd_reg & mine_reg;

   always @(posedge mclk) begin
      if (rst_any) begin
         mdio_out <= 1'b1;
         mdio_tri <= 1'b1;
      end else if (mdc_fall) begin
         // output changes only after falling edges
         if (drive_slot && in_ta && cnt_reg[0]) begin
            mdio_tri <= 1'b0;                                  // see R6 R16
            mdio_out <= 1'b0;
         end else if (drive_slot && in_data) begin
            mdio_tri <= 1'b0;                                  // see R6
            mdio_out <= sh_reg[15];
         end else begin
            mdio_tri <= 1'b1;
            mdio_out <= 1'b1;
         end
      end
   end

   // ****************************************************
   // register file and standard select
   // ****************************************************
   wire wr_go = mdc_rise & in_rdy & ~rd_reg & mine_reg &
                (hdr_op == `MDIO_OP_WR);

   always @(posedge mclk) begin
      if (rst_any) begin
         ctrl_reg       <= `CTRL_RST_VAL;
         mode_reg       <= `MODE_BASEX;
         strap_done_reg <= 1'b0;
      end else begin
         // control word holds the isolate bit
         if (wr_go && hdr_reg_a == `MDIO_REG_CTRL) begin
            ctrl_reg <= sh_reg;
         end
         if (!strap_done_reg) begin
            // strap is the reset default only
            mode_reg       <= basex_or_sgmii;                 // see R12
            strap_done_reg <= 1'b1;
         end else if (wr_go && hdr_reg_a == `MDIO_REG_MODE) begin
            mode_reg <= sh_reg[`MODE_BIT];                    // see R13 R15
         end
      end
   end

   // ****************************************************
   // gmii client datapath
   // ****************************************************
   always @(posedge mclk) begin
      if (rst_any) begin
         gmii_isolate <= 1'b0;
         sgmii_mode   <= `MODE_BASEX;
         link_ready   <= 1'b0;
      end else begin
         gmii_isolate <= ctrl_reg[`CTRL_ISO_BIT];                     // see R4
         sgmii_mode   <= mode_reg;
         link_ready   <= rdone;                                       // see R11
      end
   end

   // isolated or not ready: hold the client idle
   wire rx_open = rdone & ~ctrl_reg[`CTRL_ISO_BIT];

   always @(posedge mclk) begin
      if (rst_any) begin
         gmii_rxd   <= `GMII_IDLE;
         gmii_rx_dv <= 1'b0;
         gmii_rx_er <= 1'b0;
      end else if (rx_open) begin
         // no tx elastic buffer: tx taken on the core reference clock
         gmii_rxd   <= gmii_txd;                                      // see R1 R2 R3
         gmii_rx_dv <= gmii_tx_en;
         gmii_rx_er <= gmii_tx_er;
      end else begin
         gmii_rxd   <= `GMII_IDLE;
         gmii_rx_dv <= 1'b0;
         gmii_rx_er <= 1'b0;
      end
   end

endmodule // pcs_client_mgmt_port_shell

`default_nettype wire

// ---- common/pcs_shell_map.vh ----
// Behaviour
// R1: mac drives 8-bit txd, tx_en, tx_er
// R2: tx inputs sampled on tx clock when buffered
// R3: rx outputs synchronous to core reference clock
// R4: isolate output enables external gmii pads
// R5: management clock no faster than 2.5 MHz; the bench mdio_mac_model runs mdc at 8 MHz (HALF 62.5 ns)
// R6: mdio output enable low while driving
// R7: unused management input held high
// R8: answer only at the 5-bit phy address
// R9: integrator joins mdio signals via tristate
// R10: active-high reset clears all logic
// R11: reset-complete input ends transceiver reset
// R12: strap 0 gives 1000base-x, 1 gives sgmii
// R13: mdio writes may change the standard
// R14: strap held static in core clock domain
// R15: switching implies mdio and transceiver ports
// R16: clause-22 frames, sample on mdc rising edge
`ifndef PCS_SHELL_MAP_VH
`define PCS_SHELL_MAP_VH

`define MDIO_ST          2'b01
`define MDIO_OP_WR       2'b01
`define MDIO_OP_RD       2'b10
`define MDIO_PRE_LEN     6'h20
`define MDIO_CNT_W       6
`define MDIO_HDR_LAST    6'h0d
`define MDIO_DATA_LAST   6'h0f
`define MDIO_REG_CTRL    5'h00
`define MDIO_REG_STAT    5'h01
`define MDIO_REG_MODE    5'h10
`define CTRL_ISO_BIT     10
`define CTRL_RST_VAL     16'h0000
`define STAT_VAL         16'h0008
`define MODE_BIT         0
`define MODE_BASEX       1'b0
`define MODE_SGMII       1'b1
`define GMII_IDLE        8'h00

`endif

// ---- verif/pcs_client_mgmt_port_shell_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module pcs_shell_checker (
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       reset,
   input wire logic       reset_done,
   input wire logic       basex_or_sgmii,
   input wire logic [7:0] gmii_txd,
   input wire logic       gmii_tx_en,
   input wire logic [7:0] gmii_rxd,
   input wire logic       gmii_rx_dv,
   input wire logic       gmii_isolate,
   input wire logic       mdio_out,
   input wire logic       mdio_tri,
   input wire logic       sgmii_mode,
   input wire logic       link_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn || reset);
   a_rx_loopback: assert property (link_ready && !gmii_isolate |->
      {gmii_rx_dv, gmii_rxd} == {$past(gmii_tx_en), $past(gmii_txd)}) else $error("rx copy");
   a_rx_quiet: assert property (gmii_isolate || !link_ready |->
      !gmii_rx_dv && gmii_rxd == 8'h00) else $error("rx not quiet");
   a_reset_clear: assert property (disable iff (!resetn) reset |=>
      !gmii_rx_dv && !link_ready && mdio_tri && !gmii_isolate) else $error("reset");
   a_ready_wait: assert property (!reset_done [*5] |=> !link_ready)
      else $error("ready early");
   a_strap_mode: assert property ($rose(resetn) |-> ##[1:3] sgmii_mode == basex_or_sgmii)
      else $error("strap");
   a_ta_zero: assert property ($fell(mdio_tri) |-> (!mdio_tri && !mdio_out) [*8])
      else $error("turnaround");
   a_release_hold: assert property ($rose(mdio_tri) |-> mdio_tri [*8])
      else $error("release");
   a_mode_stable: assert property (!mdio_tri |-> $stable(sgmii_mode))
      else $error("mode moved");
   c_read: cover property ($fell(mdio_tri));
   c_iso: cover property ($rose(gmii_isolate));
   c_mode: cover property ($changed(sgmii_mode));
endmodule // pcs_shell_checker

bind pcs_client_mgmt_port_shell pcs_shell_checker chk (.mclk, .resetn, .reset, .reset_done,
   .basex_or_sgmii, .gmii_txd, .gmii_tx_en, .gmii_rxd, .gmii_rx_dv, .gmii_isolate,
   .mdio_out, .mdio_tri, .sgmii_mode, .link_ready);
`default_nettype wire

// ---- verif/mdio_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_shell_map.vh"
// ****
// management master
// ****
module mdio_mac_model #(parameter realtime HALF = 62.5) (
   output logic      mdc,
   output logic      mdio_in,
   input wire logic  mdio_out,
   input wire logic  mdio_tri
);
   logic mst_oe = 1'b1;
   logic mst_d  = 1'b1;
   initial mdc = 1'b0;
   // shared line, pulled up when released
   assign mdio_in = mst_oe ? mst_d : (mdio_tri ? 1'b1 : mdio_out);
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffffffff, `MDIO_ST, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         mst_oe = !(op == `MDIO_OP_RD && i < 18);
         mst_d = f[i];
         #HALF mdc = 1'b1;
         rd = {rd[14:0], mdio_in};
         #HALF mdc = 1'b0;
      end
      mst_oe = 1'b1;
      mst_d = 1'b1;
      #HALF mdc = 1'b1;
      #HALF mdc = 1'b0;
   endtask
endmodule // mdio_mac_model
`default_nettype wire

// ---- verif/pcs_client_mgmt_port_shell_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_shell_map.vh"
// ****
// bench
// ****
module pcs_client_mgmt_port_shell_tb_top;
   localparam logic [4:0] PHY = 5'h0b;
   logic       mclk = 1'b0, resetn = 1'b0, reset = 1'b0, reset_done = 1'b0;
   logic       basex_or_sgmii = 1'b0, gmii_tx_en = 1'b0, gmii_tx_er = 1'b0;
   logic [7:0] gmii_txd = 8'h00, gmii_rxd;
   logic       gmii_rx_dv, gmii_rx_er, gmii_isolate, mdc, mdio_in, mdio_out, mdio_tri;
   logic       sgmii_mode, link_ready;
   logic [15:0] rd;
   logic [9:0] tx_pat [3] = '{10'h2a5, 10'h15a, 10'h3ff};
   int         err_total = 0;
   int         n_checks = 0;
   always #4 mclk = ~mclk;
   pcs_client_mgmt_port_shell DUT (.mclk, .resetn, .reset, .reset_done, .basex_or_sgmii,
      .gmii_txd, .gmii_tx_en, .gmii_tx_er, .gmii_rxd, .gmii_rx_dv, .gmii_rx_er, .gmii_isolate,
      .mdc, .mdio_in, .mdio_out, .mdio_tri, .phyad(PHY), .sgmii_mode, .link_ready);
   mdio_mac_model mac (.mdc, .mdio_in, .mdio_out, .mdio_tri);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task t_strap(input logic s);
      basex_or_sgmii = s;
      resetn = 1'b0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      chk(sgmii_mode, s);
      chk(link_ready, 1'b0);
   endtask
   task t_gmii(input logic on);
      @(negedge mclk);
      for (int i = 0; i < 3; i++) begin
         {gmii_tx_en, gmii_tx_er, gmii_txd} = tx_pat[i];
         @(negedge mclk);
         chk({gmii_rx_dv, gmii_rx_er, gmii_rxd}, on ? tx_pat[i] : 10'h000);
      end
      {gmii_tx_en, gmii_tx_er, gmii_txd} = 10'h000;
   endtask
   task t_mdio;
      mac.xfer(`MDIO_OP_RD, PHY, `MDIO_REG_STAT, 16'h0000, rd);
      chk(rd, `STAT_VAL);
      mac.xfer(`MDIO_OP_RD, PHY ^ 5'h01, `MDIO_REG_STAT, 16'h0000, rd);
      chk(rd, 16'hffff);
      mac.xfer(`MDIO_OP_WR, PHY, `MDIO_REG_CTRL, 16'h0001 << `CTRL_ISO_BIT, rd);
      chk(gmii_isolate, 1'b1);
      t_gmii(1'b0);
      mac.xfer(`MDIO_OP_WR, PHY, `MDIO_REG_CTRL, `CTRL_RST_VAL, rd);
      mac.xfer(`MDIO_OP_WR, PHY ^ 5'h10, `MDIO_REG_MODE, {15'h0000, ~basex_or_sgmii}, rd);
      chk(sgmii_mode, basex_or_sgmii);
      mac.xfer(`MDIO_OP_WR, PHY, `MDIO_REG_MODE, {15'h0000, ~basex_or_sgmii}, rd);
      chk(sgmii_mode, {15'h0000, ~basex_or_sgmii});
      mac.xfer(`MDIO_OP_RD, PHY, `MDIO_REG_MODE, 16'h0000, rd);
      chk(rd, {15'h0000, ~basex_or_sgmii});
   endtask
   task t_async;
      gmii_tx_en = 1'b1;
      reset = 1'b1;
      @(negedge mclk);
      chk({link_ready, gmii_rx_dv, mdio_tri, sgmii_mode}, 4'b0010);
      reset = 1'b0;
      gmii_tx_en = 1'b0;
      repeat (12) @(negedge mclk);
      chk({link_ready, sgmii_mode}, {1'b1, basex_or_sgmii});
   endtask
   initial begin
      t_strap(1'b1);
      t_strap(1'b0);
      reset_done = 1'b1;
      repeat (6) @(negedge mclk);
      chk(link_ready, 1'b1);
      t_gmii(1'b1);
      t_mdio;
      t_gmii(1'b1);
      t_async;
      give_verdict;
   end
   initial begin
      #500000;
      err_total++;
      give_verdict;
   end
endmodule // pcs_client_mgmt_port_shell_tb_top
`default_nettype wire
